/* File: rtl/mfr_pkg.sv */
// Package: register map, response coding and bus carriers of the motor fault response block
// Operation
// - Phase overcurrent response chosen by two-bit select
// - Regulator overcurrent: Hi-Z, controller off, unreported
// - Lock conditions; 1000b reports only, 1xx1b ignores
// - Lock 0000/0001 Hi-Z, 0010/0011 brake, latched
// - Lock 0100/0101 Hi-Z, 0110/0111 brake, retry
// - Hardware lock current limit uses lock coding
// - Software lock current limit uses lock coding
// - Position detect ramp timeout: Hi-Z and retry
// - Position detect rate fault: Hi-Z and retry
// - Report on fault pin and status registers
// - Latched faults held until clear command written
// - Priority latched, slower retry, faster, report
// - Report may trail Hi-Z by up to 200 ms
package mfr_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int POS_TIMEOUT_MS = 500;
	localparam int POS_TIMEOUT_CYC = POS_TIMEOUT_MS * CYC_PER_MS;
	localparam int OCP_RETRY_MS = 5;
	localparam int LOCK_RETRY_MS = 100;
	localparam int OCP_RETRY_CYC = OCP_RETRY_MS * CYC_PER_MS;
	localparam int LOCK_RETRY_CYC = LOCK_RETRY_MS * CYC_PER_MS;
	localparam int NCH = 6;
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_CMD = 8'h04;
	localparam logic [7:0] OFS_DRV_STATUS = 8'h08;
	localparam logic [7:0] OFS_CTRL_STATUS = 8'h0C;
	localparam logic [7:0] OFS_EVT_STATUS = 8'h10;
	localparam logic [7:0] OFS_EVT_MASK = 8'h14;
	localparam int F_OCP = 0;
	localparam int F_LOCK = 2;
	localparam int F_HW = 6;
	localparam int F_SW = 10;
	localparam int F_TMO_EN = 14;
	localparam int F_RATE_EN = 15;
	localparam int F_CLEAR = 0;
	localparam logic [15:0] CONFIG_RST = 16'h0000;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [3:0] LOCK_REPORT = 4'h8;

	typedef enum logic [1:0] {ACT_NONE, ACT_HIZ, ACT_HS, ACT_LS} mfr_act_t;
	typedef struct packed {
		mfr_act_t act;
		logic latch;
		logic report;
	} mfr_resp_t;
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} mfr_axi_req_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} mfr_axi_rsp_t;

	function automatic mfr_resp_t decode_ocp(input logic [1:0] code);
		case (code)
			2'h0: decode_ocp = '{ACT_HIZ, 1'b1, 1'b1};
			2'h1: decode_ocp = '{ACT_HIZ, 1'b0, 1'b1};
			2'h2: decode_ocp = '{ACT_NONE, 1'b0, 1'b1};
			default: decode_ocp = '{ACT_NONE, 1'b0, 1'b0};
		endcase
	endfunction

	// Shared by motor lock and both lock current limits
	function automatic mfr_resp_t decode_lock(input logic [3:0] code);
		mfr_act_t a;
		a = (code[1:0] == 2'h2) ? ACT_HS : (code[1:0] == 2'h3) ? ACT_LS : ACT_HIZ;
		if (code == LOCK_REPORT)
			decode_lock = '{ACT_NONE, 1'b0, 1'b1};
		else if (code[3])
			decode_lock = '{ACT_NONE, 1'b0, 1'b0};
		else
			decode_lock = '{a, ~code[2], 1'b1};
	endfunction

	function automatic mfr_resp_t decode_enable(input logic en);
		decode_enable = en ? '{ACT_HIZ, 1'b0, 1'b1} : '{ACT_NONE, 1'b0, 1'b0};
	endfunction
endpackage

/* File: rtl/mfr_axil_slave.sv */
// AXI4-Lite slave front end: one write and one read at a time, register strobes out
`timescale 1ns/10ps
module mfr_axil_slave (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire mfr_pkg::mfr_axi_req_t axi_req_in,
	output mfr_pkg::mfr_axi_rsp_t axi_rsp_out,
	output logic wr_en_out,
	output logic [7:0] wr_addr_out,
	output logic [31:0] wr_data_out,
	output logic rd_en_out,
	output logic [7:0] rd_addr_out,
	input wire logic [31:0] rd_data_in,
	input wire logic rd_hit_in,
	input wire logic wr_hit_in
);
	import mfr_pkg::*;
	logic aw_have;
	logic w_have;
	logic do_write;
	logic do_read;
	// Channel flops kept apart so each has a single driving process
	logic aw_rdy;
	logic w_rdy;
	logic b_vld;
	logic [1:0] b_resp;
	logic ar_rdy;
	logic r_vld;
	logic [31:0] r_data;
	logic [1:0] r_resp;

	assign axi_rsp_out = '{aw_rdy, w_rdy, b_vld, b_resp, ar_rdy, r_vld, r_data, r_resp};
	assign do_write = aw_have && w_have && !b_vld;
	assign do_read = axi_req_in.arvalid && ar_rdy;
	assign wr_en_out = do_write && (&wr_data_strb_ok());
	assign rd_en_out = do_read;
	assign rd_addr_out = axi_req_in.araddr;

	// Write strobes are ignored and every write takes the whole word: all fields sit in the low half-word
	function automatic logic wr_data_strb_ok();
		wr_data_strb_ok = 1'b1;
	endfunction

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			wr_addr_out <= 8'h00;
			wr_data_out <= 32'h0000_0000;
			aw_rdy <= 1'b1;
			w_rdy <= 1'b1;
			b_vld <= 1'b0;
			b_resp <= RESP_OK;
		end else begin
			if (axi_req_in.awvalid && aw_rdy) begin
				aw_have <= 1'b1;
				wr_addr_out <= axi_req_in.awaddr;
				aw_rdy <= 1'b0;
			end
			if (axi_req_in.wvalid && w_rdy) begin
				w_have <= 1'b1;
				wr_data_out <= axi_req_in.wdata;
				w_rdy <= 1'b0;
			end
			if (do_write) begin
				aw_have <= 1'b0;
				w_have <= 1'b0;
				b_vld <= 1'b1;
				b_resp <= wr_hit_in ? RESP_OK : RESP_SLVERR;
			end
			if (b_vld && axi_req_in.bready) begin
				b_vld <= 1'b0;
				aw_rdy <= 1'b1;
				w_rdy <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ar_rdy <= 1'b1;
			r_vld <= 1'b0;
			r_data <= 32'h0000_0000;
			r_resp <= RESP_OK;
		end else if (do_read) begin
			ar_rdy <= 1'b0;
			r_vld <= 1'b1;
			r_data <= rd_data_in;
			r_resp <= rd_hit_in ? RESP_OK : RESP_SLVERR;
		end else if (r_vld && axi_req_in.rready) begin
			r_vld <= 1'b0;
			ar_rdy <= 1'b1;
		end
	end
endmodule

/* File: rtl/mfr_fault_channel.sv */
// One fault source: latch, retry timing and report state for a decoded response
`timescale 1ns/10ps
module mfr_fault_channel #(
	parameter int RETRY_CYC = 1000
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic cond_in,
	input wire mfr_pkg::mfr_resp_t resp_in,
	input wire logic clear_in,
	output logic engaged_out,
	output logic latched_out,
	output mfr_pkg::mfr_act_t act_out,
	output logic report_out
);
	import mfr_pkg::*;
	typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_RETRY} mfr_ch_state_t;
	mfr_ch_state_t state;
	logic [31:0] count;

	assign engaged_out = (state != ST_IDLE);
	assign report_out = engaged_out || (cond_in && resp_in.report);

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state <= ST_IDLE;
			count <= 32'h0000_0000;
			latched_out <= 1'b0;
			act_out <= ACT_NONE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (cond_in && resp_in.act != ACT_NONE) begin
						state <= ST_HOLD;
						latched_out <= resp_in.latch;
						act_out <= resp_in.act;
					end
				end
				ST_HOLD: begin
					if (latched_out) begin
						if (clear_in) begin
							state <= ST_IDLE;
							latched_out <= 1'b0;
						end
					end else if (!cond_in) begin
						state <= ST_RETRY;
						count <= 32'h0000_0000;
					end
				end
				ST_RETRY: begin
					if (cond_in) begin
						state <= ST_HOLD;
					end else if (count >= 32'(RETRY_CYC - 1)) begin
						state <= ST_IDLE;
					end else begin
						count <= count + 32'h0000_0001;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
endmodule

/* File: rtl/mfr_fault_response.sv */
// Motor fault response top: fault decode, output override, report pin and registers
`timescale 1ns/10ps
module mfr_fault_response #(
	parameter int POS_TIMEOUT_CYCLES = mfr_pkg::POS_TIMEOUT_CYC,
	parameter int OCP_RETRY_CYCLES = mfr_pkg::OCP_RETRY_CYC,
	parameter int LOCK_RETRY_CYCLES = mfr_pkg::LOCK_RETRY_CYC
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire mfr_pkg::mfr_axi_req_t axi_req_in,
	output mfr_pkg::mfr_axi_rsp_t axi_rsp_out,
	input wire logic phase_overcurrent_in,
	input wire logic regulator_overcurrent_in,
	input wire logic motor_lock_fault_in,
	input wire logic hw_lock_current_over_in,
	input wire logic sw_lock_current_over_in,
	input wire logic pos_ramp_active_in,
	input wire logic pos_pulse_start_in,
	input wire logic pos_current_decayed_in,
	input wire logic [2:0] drive_hs_in,
	input wire logic [2:0] drive_ls_in,
	output logic [2:0] hs_gate_out,
	output logic [2:0] ls_gate_out,
	output logic controller_enable_out,
	output logic fault_pin_active_low_out,
	output logic irq_out
);
	import mfr_pkg::*;
	logic [15:0] config_reg;
	logic [NCH-1:0] evt_status;
	logic [NCH-1:0] evt_mask;
	logic [NCH-1:0] report_q;
	logic [31:0] tmo_count;
	logic clear_pulse;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic rd_en;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_hit;
	logic wr_hit;
	logic tmo_cond;
	logic rate_cond;
	logic [NCH-1:0] cond;
	mfr_resp_t resp [NCH];
	logic [NCH-1:0] engaged;
	logic [NCH-1:0] latched;
	logic [NCH-1:0] report;
	mfr_act_t act [NCH];
	mfr_act_t next_act;

	function automatic logic is_reg(input logic [7:0] a);
		is_reg = (a == OFS_CONFIG) || (a == OFS_CMD) || (a == OFS_DRV_STATUS) ||
			(a == OFS_CTRL_STATUS) || (a == OFS_EVT_STATUS) || (a == OFS_EVT_MASK);
	endfunction

	mfr_axil_slave u_bus (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.axi_req_in(axi_req_in),
		.axi_rsp_out(axi_rsp_out),
		.wr_en_out(wr_en),
		.wr_addr_out(wr_addr),
		.wr_data_out(wr_data),
		.rd_en_out(rd_en),
		.rd_addr_out(rd_addr),
		.rd_data_in(rd_data),
		.rd_hit_in(rd_hit),
		.wr_hit_in(wr_hit)
	);

	assign rd_hit = is_reg(rd_addr);
	assign wr_hit = is_reg(wr_addr);

	// Ramp timeout counter saturates so the condition holds until the ramp ends
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tmo_count <= 32'h0000_0000;
		end else if (!pos_ramp_active_in) begin
			tmo_count <= 32'h0000_0000;
		end else if (tmo_count < 32'(POS_TIMEOUT_CYCLES)) begin
			tmo_count <= tmo_count + 32'h0000_0001;
		end
	end

	assign tmo_cond = pos_ramp_active_in && (tmo_count >= 32'(POS_TIMEOUT_CYCLES));
	assign rate_cond = pos_pulse_start_in && !pos_current_decayed_in;
	assign cond = {rate_cond, tmo_cond, sw_lock_current_over_in, hw_lock_current_over_in,
		motor_lock_fault_in, phase_overcurrent_in};

	always_comb begin
		resp[0] = decode_ocp(config_reg[F_OCP +: 2]);
		resp[1] = decode_lock(config_reg[F_LOCK +: 4]);
		resp[2] = decode_lock(config_reg[F_HW +: 4]);
		resp[3] = decode_lock(config_reg[F_SW +: 4]);
		resp[4] = decode_enable(config_reg[F_TMO_EN]);
		resp[5] = decode_enable(config_reg[F_RATE_EN]);
	end

	for (genvar i = 0; i < NCH; i++) begin : g_ch
		mfr_fault_channel #(
			.RETRY_CYC((i == 0) ? OCP_RETRY_CYCLES : LOCK_RETRY_CYCLES)
		) u_ch (
			.clk_in(clk_in),
			.rst_b_in(rst_b_in),
			.cond_in(cond[i]),
			.resp_in(resp[i]),
			.clear_in(clear_pulse),
			.engaged_out(engaged[i]),
			.latched_out(latched[i]),
			.act_out(act[i]),
			.report_out(report[i])
		);
	end

	// Rank an engaged channel; a channel left in retry holds its override
	// until its own timer ends, so recovery waits for the longest retry
	function automatic logic [1:0] rank(input int i);
		logic slow;
		slow = (i == 0) ? (OCP_RETRY_CYCLES >= LOCK_RETRY_CYCLES) :
			(LOCK_RETRY_CYCLES >= OCP_RETRY_CYCLES);
		if (!engaged[i])
			rank = 2'h0;
		else if (latched[i])
			rank = 2'h3;
		else
			rank = slow ? 2'h2 : 2'h1;
	endfunction

	always_comb begin
		logic [1:0] best;
		best = 2'h0;
		next_act = ACT_NONE;
		for (int i = 0; i < NCH; i++) begin
			if (rank(i) > best) begin
				best = rank(i);
				next_act = act[i];
			end
		end
	end

	// Regulator overcurrent forces Hi-Z over any brake and is never reported
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			hs_gate_out <= 3'b000;
			ls_gate_out <= 3'b000;
			controller_enable_out <= 1'b0;
		end else begin
			controller_enable_out <= !regulator_overcurrent_in;
			if (regulator_overcurrent_in) begin
				hs_gate_out <= 3'b000;
				ls_gate_out <= 3'b000;
			end else begin
				case (next_act)
					ACT_NONE: begin
						hs_gate_out <= drive_hs_in;
						ls_gate_out <= drive_ls_in;
					end
					ACT_HS: begin
						hs_gate_out <= 3'b111;
						ls_gate_out <= 3'b000;
					end
					ACT_LS: begin
						hs_gate_out <= 3'b000;
						ls_gate_out <= 3'b111;
					end
					default: begin
						hs_gate_out <= 3'b000;
						ls_gate_out <= 3'b000;
					end
				endcase
			end
		end
	end

	// Report leads the override by one cycle, well inside the allowed delay
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			report_q <= '0;
			fault_pin_active_low_out <= 1'b1;
		end else begin
			report_q <= report;
			fault_pin_active_low_out <= ~(|report);
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			config_reg <= CONFIG_RST;
			evt_mask <= '0;
			clear_pulse <= 1'b0;
		end else begin
			clear_pulse <= wr_en && (wr_addr == OFS_CMD) && wr_data[F_CLEAR];
			if (wr_en && wr_addr == OFS_CONFIG)
				config_reg <= wr_data[15:0];
			if (wr_en && wr_addr == OFS_EVT_MASK)
				evt_mask <= wr_data[NCH-1:0];
		end
	end

	// A new report edge wins over a read clear in the same cycle
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			evt_status <= '0;
			irq_out <= 1'b0;
		end else begin
			evt_status <= ((rd_en && rd_addr == OFS_EVT_STATUS) ? '0 : evt_status) |
				(report & ~report_q);
			irq_out <= |(evt_status & evt_mask);
		end
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		case (rd_addr)
			OFS_CONFIG: rd_data[15:0] = config_reg;
			OFS_DRV_STATUS: rd_data[0] = report_q[0];
			OFS_CTRL_STATUS: rd_data[NCH-2:0] = report_q[NCH-1:1];
			OFS_EVT_STATUS: rd_data[NCH-1:0] = evt_status;
			OFS_EVT_MASK: rd_data[NCH-1:0] = evt_mask;
			default: rd_data = 32'h0000_0000;
		endcase
	end
endmodule

/* File: bench/mfr_stage_model.sv */
// Partner model: power stage and position-detect sense lines seen by the fault block
`timescale 1ns/10ps
module mfr_stage_model (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic [5:0] inject_in,
	output logic [4:0] cond_out,
	output logic pulse_out,
	output logic decayed_out
);
	// Sense comparators settle one cycle after the event, so the block never sees a free edge
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cond_out <= 5'h00;
			pulse_out <= 1'b0;
			decayed_out <= 1'b1;
		end else begin
			cond_out <= inject_in[4:0];
			pulse_out <= inject_in[5];
			decayed_out <= ~inject_in[5];
		end
	end
endmodule

/* File: bench/mfr_fault_response_sva.sv */
// Checker: timing relations of the fault response block at its ports
`timescale 1ns/10ps
module mfr_fault_response_sva (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire mfr_pkg::mfr_axi_req_t axi_req_in,
	input wire mfr_pkg::mfr_axi_rsp_t axi_rsp_out,
	input wire logic phase_overcurrent_in,
	input wire logic regulator_overcurrent_in,
	input wire logic motor_lock_fault_in,
	input wire logic hw_lock_current_over_in,
	input wire logic sw_lock_current_over_in,
	input wire logic pos_ramp_active_in,
	input wire logic pos_pulse_start_in,
	input wire logic pos_current_decayed_in,
	input wire logic [2:0] drive_hs_in,
	input wire logic [2:0] drive_ls_in,
	input wire logic [2:0] hs_gate_out,
	input wire logic [2:0] ls_gate_out,
	input wire logic controller_enable_out,
	input wire logic fault_pin_active_low_out,
	input wire logic irq_out
);
	import mfr_pkg::*;
	logic cond_any;
	assign cond_any = phase_overcurrent_in | motor_lock_fault_in | hw_lock_current_over_in
		| sw_lock_current_over_in | pos_ramp_active_in | pos_pulse_start_in;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	property p_fall_cause;
		$fell(fault_pin_active_low_out) |->
			($past(cond_any) || $past(cond_any, 2) || $past(cond_any, 3));
	endproperty
	a_fall_cause: assert property (p_fall_cause) else $error("pin fell with no cause");
	// Hi-Z with the controller alive can only come from an acted-on fault
	property p_hiz_report;
		(hs_gate_out == 3'h0 && ls_gate_out == 3'h0 && controller_enable_out
			&& $past(controller_enable_out) && $past(controller_enable_out, 2))
			|-> !fault_pin_active_low_out;
	endproperty
	a_hiz_report: assert property (p_hiz_report) else $error("Hi-Z not reported");
	property p_brake_report;
		({hs_gate_out, ls_gate_out} == 6'h38 || {hs_gate_out, ls_gate_out} == 6'h07)
			|-> !fault_pin_active_low_out;
	endproperty
	a_brake_report: assert property (p_brake_report) else $error("brake not reported");
	property p_reg_hiz;
		regulator_overcurrent_in |->
			##[1:3] (!controller_enable_out && hs_gate_out == 3'h0 && ls_gate_out == 3'h0);
	endproperty
	a_reg_hiz: assert property (p_reg_hiz) else $error("regulator fault not acted on");
	property p_reg_back;
		$fell(regulator_overcurrent_in) |-> ##[1:3] controller_enable_out;
	endproperty
	a_reg_back: assert property (p_reg_back) else $error("controller did not recover");
	property p_irq_cause;
		$rose(irq_out) |-> (!$past(fault_pin_active_low_out) ||
			!$past(fault_pin_active_low_out, 2) || !$past(fault_pin_active_low_out, 3));
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq with no report");
	property p_r_answer;
		(axi_req_in.arvalid && axi_rsp_out.arready) |=> axi_rsp_out.rvalid;
	endproperty
	a_r_answer: assert property (p_r_answer) else $error("read answer late");
	property p_w_answer;
		(axi_req_in.awvalid && axi_rsp_out.awready && axi_req_in.wvalid && axi_rsp_out.wready)
			|-> ##2 axi_rsp_out.bvalid;
	endproperty
	a_w_answer: assert property (p_w_answer) else $error("write answer late");
endmodule
bind mfr_fault_response mfr_fault_response_sva u_sva (.clk_in(clk_in), .rst_b_in(rst_b_in),
	.axi_req_in(axi_req_in), .axi_rsp_out(axi_rsp_out),
	.phase_overcurrent_in(phase_overcurrent_in), .regulator_overcurrent_in(regulator_overcurrent_in),
	.motor_lock_fault_in(motor_lock_fault_in), .hw_lock_current_over_in(hw_lock_current_over_in),
	.sw_lock_current_over_in(sw_lock_current_over_in), .pos_ramp_active_in(pos_ramp_active_in),
	.pos_pulse_start_in(pos_pulse_start_in), .pos_current_decayed_in(pos_current_decayed_in),
	.drive_hs_in(drive_hs_in), .drive_ls_in(drive_ls_in), .hs_gate_out(hs_gate_out),
	.ls_gate_out(ls_gate_out), .controller_enable_out(controller_enable_out),
	.fault_pin_active_low_out(fault_pin_active_low_out), .irq_out(irq_out));

/* File: bench/mfr_fault_response_bench.sv */
// Testbench: fault codes, recovery, status, interrupt and regulator cases
`timescale 1ns/10ps
module mfr_fault_response_bench;
	import mfr_pkg::*;
	// {config, source, action, kind}: kind 0 latched, 1 retry, 2 report, 3 ignore
	localparam logic [23:0] TBL [22] = '{24'h00_0004, 24'h00_0105, 24'h00_0202, 24'h00_0303,
		24'h00_0414, 24'h00_0818, 24'h00_0C1C, 24'h00_1415, 24'h00_1819, 24'h00_1C1D,
		24'h00_2012, 24'h00_2C13, 24'h00_0024, 24'h01_8029, 24'h03_4023, 24'h0C_003C,
		24'h10_0035, 24'h20_0032, 24'h40_0045, 24'h00_0043, 24'h80_0055, 24'h00_0053};
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	mfr_axi_req_t req = '0;
	mfr_axi_rsp_t rsp;
	logic [5:0] inj = 6'h00;
	logic reg_oc = 1'b0;
	logic [2:0] dh = 3'h1;
	logic [2:0] dl = 3'h0;
	logic [2:0] hs, ls;
	logic [4:0] cnd;
	logic en, pin, irq, ps, dc;
	logic [31:0] seed = 32'h0000_0021;
	logic [33:0] rq [$];
	int mismatches = 0;
	int num_checks = 0;
	int cyc = 0;
	always #10 clk_in = ~clk_in;
	mfr_stage_model u_stage (.clk_in(clk_in), .rst_b_in(rst_b_in), .inject_in(inj),
		.cond_out(cnd), .pulse_out(ps), .decayed_out(dc));
	mfr_fault_response #(.POS_TIMEOUT_CYCLES(20), .OCP_RETRY_CYCLES(5), .LOCK_RETRY_CYCLES(10))
	u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .axi_req_in(req), .axi_rsp_out(rsp),
		.phase_overcurrent_in(cnd[0]), .regulator_overcurrent_in(reg_oc),
		.motor_lock_fault_in(cnd[1]), .hw_lock_current_over_in(cnd[2]),
		.sw_lock_current_over_in(cnd[3]), .pos_ramp_active_in(cnd[4]),
		.pos_pulse_start_in(ps), .pos_current_decayed_in(dc), .drive_hs_in(dh),
		.drive_ls_in(dl), .hs_gate_out(hs), .ls_gate_out(ls), .controller_enable_out(en),
		.fault_pin_active_low_out(pin), .irq_out(irq));
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		xs = x ^ (x << 5);
	endfunction
	task automatic chk(input logic [33:0] s, input logic [33:0] e);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	// Gates and pin against an action code; none means the drive requests pass through
	task automatic gchk(input logic [1:0] a, input logic p);
		logic [5:0] g;
		g = (a == 2'h1) ? 6'h00 : (a == 2'h2) ? 6'h38 : (a == 2'h3) ? 6'h07 : {dh, dl};
		chk(34'({hs, ls, pin}), 34'({g, p}));
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		do begin
			@(posedge clk_in);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		req.bready <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic axr(input logic [7:0] a, input logic [33:0] e);
		rq.push_back(e);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do begin
			@(posedge clk_in);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		req.rready <= 1'b0;
		@(posedge clk_in);
	endtask
	always @(posedge clk_in) begin
		if (rsp.rvalid && req.rready) chk({rsp.rresp, rsp.rdata}, rq.pop_front());
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			wrap_up();
		end
	end
	initial begin
		logic [23:0] t;
		int s, k, h;
		tick(2);
		rst_b_in <= 1'b1;
		axr(OFS_CONFIG, 34'(CONFIG_RST));
		axr(8'h20, {RESP_SLVERR, 32'h0000_0000});
		axw(OFS_CONFIG, 32'hFFFF_FFFF);
		axr(OFS_CONFIG, 34'h0_FFFF);
		for (int i = 0; i < 22; i++) begin
			t = TBL[i];
			s = t[7:4];
			k = t[1:0];
			h = (s == 4) ? 30 : (s == 5) ? 1 : 4;
			axw(OFS_CONFIG, {16'h0000, t[23:8]});
			seed = xs(seed);
			dh <= {1'b0, seed[0], 1'b1};
			dl <= {seed[1], 2'h0};
			tick(3);
			inj[s] <= 1'b1;
			tick(h);
			if (h > 1) gchk(t[3:2], k == 3);
			inj[s] <= 1'b0;
			tick(4);
			gchk(k < 2 ? t[3:2] : 2'h0, k > 1);
			if (k == 0) begin
				axr(s == 0 ? OFS_DRV_STATUS : OFS_CTRL_STATUS, 34'(s == 0 ? 1 : 1 << (s - 1)));
				axw(OFS_CMD, 32'h0000_0001);
			end
			tick(k == 1 ? 20 : 4);
			gchk(2'h0, 1'b1);
			axr(OFS_EVT_STATUS, k == 3 ? 34'h0 : 34'(1 << s));
			$display("test %0d done", i);
		end
		axw(OFS_CONFIG, 32'h0000_0009);
		inj <= 6'h03;
		tick(4);
		inj <= 6'h00;
		tick(20);
		gchk(2'h2, 1'b0);
		axw(OFS_CMD, 32'h0000_0001);
		tick(4);
		gchk(2'h0, 1'b1);
		axr(OFS_EVT_STATUS, 34'h3);
		$display("test priority done");
		for (int m = 1; m < 3; m++) begin
			axw(OFS_CONFIG, 32'h0000_0002);
			axw(OFS_EVT_MASK, 32'(m));
			inj[0] <= 1'b1;
			tick(6);
			chk(34'(irq), 34'(m == 1));
			inj[0] <= 1'b0;
			axr(OFS_EVT_STATUS, 34'h1);
			tick(2);
			chk(34'(irq), 34'h0);
		end
		$display("test interrupt done");
		reg_oc <= 1'b1;
		tick(4);
		chk(34'({en, hs, ls, pin}), 34'h1);
		reg_oc <= 1'b0;
		tick(4);
		chk(34'({en, hs, ls, pin}), 34'({1'b1, dh, dl, 1'b1}));
		rst_b_in <= 1'b0;
		tick(2);
		chk(34'({en, hs, ls, pin, irq}), 34'h2);
		rst_b_in <= 1'b1;
		tick(3);
		chk(34'({en, hs, ls, pin}), 34'({1'b1, dh, dl, 1'b1}));
		$display("test regulator and reset done");
		wrap_up();
	end
endmodule
